// *** include/switch_flags_pkg.sv ***
// Purpose: Shared constants and types for the switch capacity and bit-error flag block.
// Assumes: APB with 32-bit data; every register sits in one aligned word.
// Notes:   Register positions are word indices; the byte address is four times the index.
package switch_flags_pkg;

	// Switch core sizing.
	localparam int STREAM_COUNT      = 32;
	localparam int BER_FLAG_COUNT    = 16;
	localparam int CAPACITY_CHANNELS = 4096;
	localparam int BASE_CHANNELS     = 32;  // Channels per frame at the slowest rate code.
	localparam int RATE_W            = 2;
	localparam int SUM_W             = 14;  // Holds 32 streams of 256 channels.
	localparam int COUNT_W           = 16;  // Width of one receiver error count.
	localparam int IRQ_W             = 2 + BER_FLAG_COUNT;

	// Word indices of the registers.
	localparam logic [9:0] IDX_FP_OFFSET  = 10'h00f;
	localparam logic [9:0] IDX_CAP_FLAGS  = 10'h010;
	localparam logic [9:0] IDX_BER_FLAGS  = 10'h011;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h020;
	localparam logic [9:0] IDX_IRQ_CLEAR  = 10'h021;
	localparam logic [9:0] IDX_IRQ_ENABLE = 10'h022;
	localparam logic [9:0] IDX_IN_CFG     = 10'h040;
	localparam logic [9:0] IDX_OUT_CFG    = 10'h060;

	// Field positions.
	localparam int CAP_IN_BIT   = 0;
	localparam int CAP_OUT_BIT  = 1;
	localparam int IRQ_BER_LSB  = 2;
	localparam int CFG_RATE_LSB = 0;
	localparam int CFG_EN_BIT   = 2;

	// Values after reset and read masks.
	localparam logic [15:0] FP_OFFSET_RESET = 16'h0000;
	localparam logic [15:0] FP_OFFSET_MASK  = 16'h07ff;
	localparam logic [15:0] FLAGS_RESET     = 16'h0000;

	// Per-stream configuration: enable and rate code (00 slowest .. 11 fastest).
	typedef struct packed {
		logic              enable;
		logic [RATE_W-1:0] rate;
	} stream_cfg_t;

	// The two capacity flags, output_capacity_error in bit 1 and input_capacity_error in bit 0.
	typedef struct packed {
		logic output_capacity_error;
		logic input_capacity_error;
	} cap_flags_t;

	localparam stream_cfg_t CFG_RESET = '{enable: 1'b0, rate: 2'h0};

endpackage

// *** rtl/channel_count_sum.sv ***
// Purpose: Adds up the channels per frame of all enabled streams.
// Assumes: Rate code n gives the base channel count shifted left by n.
// Notes:   Purely combinational; the caller registers the capacity flags it derives from the result.
`timescale 1ns/10ps
module channel_count_sum #(
	parameter int Streams = switch_flags_pkg::STREAM_COUNT
) (
	input  switch_flags_pkg::stream_cfg_t [Streams-1:0] streamCfg,
	output logic [switch_flags_pkg::SUM_W-1:0]           channelTotal
);

	logic [switch_flags_pkg::SUM_W-1:0] partial [Streams+1];

	// A chained sum; a disabled stream carries nothing to the core.
	assign partial[0] = '0;
	for (genvar i = 0; i < Streams; i++) begin : gSum
		logic [switch_flags_pkg::SUM_W-1:0] streamChans;
		assign streamChans = streamCfg[i].enable ?
			switch_flags_pkg::SUM_W'(switch_flags_pkg::BASE_CHANNELS) << streamCfg[i].rate :
			'0;
		assign partial[i+1] = partial[i] + streamChans;
	end
	assign channelTotal = partial[Streams];

endmodule

// *** rtl/switch_capacity_and_ber_flags.sv ***
// Purpose: APB register bank with capacity checks, bit-error flags and an interrupt.
// Assumes: Error counts come from logic on ref_clk; reset is synchronous active high.
// Notes:   Flags lag their causes by one cycle; pready rises in the first access cycle.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
module switch_capacity_and_ber_flags #(
	parameter int Streams  = switch_flags_pkg::STREAM_COUNT,
	parameter int BerFlags = switch_flags_pkg::BER_FLAG_COUNT
) (
	input  wire logic                                               ref_clk,
	input  wire logic                                               rst,
	input  wire logic                                               psel,
	input  wire logic                                               penable,
	input  wire logic                                               pwrite,
	input  wire logic [11:0]                                        paddr,
	input  wire logic [31:0]                                        pwdata,
	output logic                                                    pready,
	output logic [31:0]                                             prdata,
	output logic                                                    pslverr,
	input  wire logic [BerFlags-1:0][switch_flags_pkg::COUNT_W-1:0] berReceiverErrorCount,
	output logic                                                    outputCapacityError,
	output logic                                                    inputCapacityError,
	output logic [BerFlags-1:0]                                     berStreamErrorFlag,
	output logic [15:0]                                             framePulseOffset,
	output switch_flags_pkg::stream_cfg_t [Streams-1:0]             inStreamCfg,
	output switch_flags_pkg::stream_cfg_t [Streams-1:0]             outStreamCfg,
	output logic                                                    irq
);

	localparam int IrqW = 2 + BerFlags;

	// Refuse sizes that break the register layout or overflow the channel sum.
	if (Streams < 1 || Streams > switch_flags_pkg::STREAM_COUNT) begin : gBadStreams
		$error("Streams must lie between 1 and 32.");
	end
	if (BerFlags < 1 || BerFlags > switch_flags_pkg::BER_FLAG_COUNT) begin : gBadBer
		$error("BerFlags must lie between 1 and 16.");
	end

	// Configuration state.
	switch_flags_pkg::stream_cfg_t [Streams-1:0] inCfg_r;
	switch_flags_pkg::stream_cfg_t [Streams-1:0] inCfg_nxt;
	switch_flags_pkg::stream_cfg_t [Streams-1:0] outCfg_r;
	switch_flags_pkg::stream_cfg_t [Streams-1:0] outCfg_nxt;
	logic [15:0]                                 fpOffset_r;
	logic [15:0]                                 fpOffset_nxt;

	// Flag and interrupt state.
	switch_flags_pkg::cap_flags_t                capFlags_r;
	switch_flags_pkg::cap_flags_t                capFlags_nxt;
	logic [BerFlags-1:0]                         berFlags_r;
	logic [BerFlags-1:0]                         berFlags_nxt;
	logic [IrqW-1:0]                             irqStatus_r;
	logic [IrqW-1:0]                             irqStatus_nxt;
	logic [IrqW-1:0]                             irqEnable_r;
	logic [IrqW-1:0]                             irqEnable_nxt;
	logic                                        irq_r;
	logic                                        irq_nxt;

	// Bus answer state.
	logic                                        pready_r;
	logic                                        pready_nxt;
	logic [31:0]                                 prdata_r;
	logic [31:0]                                 prdata_nxt;
	logic                                        pslverr_r;
	logic                                        pslverr_nxt;

	// Decode helpers.
	logic [switch_flags_pkg::SUM_W-1:0]          inTotal;
	logic [switch_flags_pkg::SUM_W-1:0]          outTotal;
	logic [9:0]                                  wordIdx;
	logic                                        setupPhase;
	logic                                        writeDone;
	logic                                        hitInCfg;
	logic                                        hitOutCfg;
	logic [4:0]                                  cfgSel;
	logic [IrqW-1:0]                             irqEvents;
	logic [IrqW-1:0]                             irqClear;
	logic [IrqW-1:0]                             flagNow;
	logic [IrqW-1:0]                             flagPrev_r;

	assign wordIdx    = paddr[11:2];
	assign setupPhase = psel && !penable;
	assign writeDone  = psel && penable && pready_r && pwrite;
	assign cfgSel     = wordIdx[4:0];
	assign hitInCfg   = (wordIdx >= switch_flags_pkg::IDX_IN_CFG) &&
		(wordIdx < switch_flags_pkg::IDX_IN_CFG + 10'(Streams));
	assign hitOutCfg  = (wordIdx >= switch_flags_pkg::IDX_OUT_CFG) &&
		(wordIdx < switch_flags_pkg::IDX_OUT_CFG + 10'(Streams));

	// Channel totals of the enabled streams on each side.
	channel_count_sum #(
		.Streams(Streams)
	) uInSum (
		.streamCfg   (inCfg_r),
		.channelTotal(inTotal)
	);

	channel_count_sum #(
		.Streams(Streams)
	) uOutSum (
		.streamCfg   (outCfg_r),
		.channelTotal(outTotal)
	);

	// Configuration writes. Disabling streams is how software brings the totals back down.
	always_comb begin
		inCfg_nxt    = inCfg_r;
		outCfg_nxt   = outCfg_r;
		fpOffset_nxt = fpOffset_r;
		if (writeDone) begin
			if (wordIdx == switch_flags_pkg::IDX_FP_OFFSET) begin
				fpOffset_nxt = pwdata[15:0] & switch_flags_pkg::FP_OFFSET_MASK;
			end else if (hitInCfg) begin
				inCfg_nxt[cfgSel] = pwdata[switch_flags_pkg::CFG_EN_BIT:0];
			end else if (hitOutCfg) begin
				outCfg_nxt[cfgSel] = pwdata[switch_flags_pkg::CFG_EN_BIT:0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			inCfg_r    <= {Streams{switch_flags_pkg::CFG_RESET}};
			outCfg_r   <= {Streams{switch_flags_pkg::CFG_RESET}};
			fpOffset_r <= switch_flags_pkg::FP_OFFSET_RESET;
		end else begin
			inCfg_r    <= inCfg_nxt;
			outCfg_r   <= outCfg_nxt;
			fpOffset_r <= fpOffset_nxt;
		end
	end

	// Flags follow their causes every cycle, with no latch, so they fall on their own.
	always_comb begin
		capFlags_nxt.output_capacity_error = outTotal > switch_flags_pkg::SUM_W'(
			switch_flags_pkg::CAPACITY_CHANNELS);
		capFlags_nxt.input_capacity_error  = inTotal > switch_flags_pkg::SUM_W'(
			switch_flags_pkg::CAPACITY_CHANNELS);
		for (int i = 0; i < BerFlags; i++) begin
			berFlags_nxt[i] = |berReceiverErrorCount[i];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			capFlags_r <= '0;
			berFlags_r <= '0;
		end else begin
			capFlags_r <= capFlags_nxt;
			berFlags_r <= berFlags_nxt;
		end
	end

	// Interrupt events are rising edges of the flags; a new event beats a clear in the same cycle.
	assign flagNow  = {berFlags_r, capFlags_r.output_capacity_error, capFlags_r.input_capacity_error};
	assign irqClear = (writeDone && wordIdx == switch_flags_pkg::IDX_IRQ_CLEAR) ?
		pwdata[IrqW-1:0] : '0;
	assign irqEvents = flagNow & ~flagPrev_r;

	always_comb begin
		irqStatus_nxt = (irqStatus_r & ~irqClear) | irqEvents;
		irqEnable_nxt = irqEnable_r;
		if (writeDone && wordIdx == switch_flags_pkg::IDX_IRQ_ENABLE) begin
			irqEnable_nxt = pwdata[IrqW-1:0];
		end
		irq_nxt = |(irqStatus_nxt & irqEnable_nxt);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irqStatus_r <= '0;
			irqEnable_r <= '0;
			flagPrev_r  <= '0;
			irq_r       <= 1'b0;
		end else begin
			irqStatus_r <= irqStatus_nxt;
			irqEnable_r <= irqEnable_nxt;
			flagPrev_r  <= flagNow;
			irq_r       <= irq_nxt;
		end
	end

	// Read data is captured in the setup cycle so every answer comes from a flip-flop.
	// Writes to read-only words and any unmapped access answer with pslverr.
	always_comb begin
		pready_nxt  = setupPhase;
		prdata_nxt  = prdata_r;
		pslverr_nxt = 1'b0;
		if (setupPhase) begin
			prdata_nxt = '0;
			if (wordIdx == switch_flags_pkg::IDX_FP_OFFSET) begin
				prdata_nxt[15:0] = fpOffset_r;
			end else if (wordIdx == switch_flags_pkg::IDX_CAP_FLAGS) begin
				prdata_nxt[1:0] = capFlags_r;
				pslverr_nxt     = pwrite;
			end else if (wordIdx == switch_flags_pkg::IDX_BER_FLAGS) begin
				prdata_nxt[BerFlags-1:0] = berFlags_r;
				pslverr_nxt              = pwrite;
			end else if (wordIdx == switch_flags_pkg::IDX_IRQ_STATUS) begin
				prdata_nxt[IrqW-1:0] = irqStatus_r;
				pslverr_nxt          = pwrite;
			end else if (wordIdx == switch_flags_pkg::IDX_IRQ_CLEAR) begin
				pslverr_nxt = !pwrite;
			end else if (wordIdx == switch_flags_pkg::IDX_IRQ_ENABLE) begin
				prdata_nxt[IrqW-1:0] = irqEnable_r;
			end else if (hitInCfg) begin
				prdata_nxt[switch_flags_pkg::CFG_EN_BIT:0] = inCfg_r[cfgSel];
			end else if (hitOutCfg) begin
				prdata_nxt[switch_flags_pkg::CFG_EN_BIT:0] = outCfg_r[cfgSel];
			end else begin
				pslverr_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready_r  <= 1'b0;
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= pready_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Every output is a register.
	assign pready              = pready_r;
	assign prdata              = prdata_r;
	assign pslverr             = pslverr_r;
	assign outputCapacityError = capFlags_r.output_capacity_error;
	assign inputCapacityError  = capFlags_r.input_capacity_error;
	assign berStreamErrorFlag  = berFlags_r;
	assign framePulseOffset    = fpOffset_r;
	assign inStreamCfg         = inCfg_r;
	assign outStreamCfg        = outCfg_r;
	assign irq                 = irq_r;

endmodule

// *** dv/switch_flags_props.sv ***
// Purpose: Concurrent checks on the capacity and bit-error flag outputs.
// Assumes: Flags lag their causes by one cycle; reads answer with no wait state.
// Notes:   Channel totals are rebuilt here from the registered stream config outputs.
`timescale 1ns/10ps
module switch_flags_props #(
	parameter int Streams  = 32,
	parameter int BerFlags = 16
) (
	input wire logic                                               ref_clk,
	input wire logic                                               rst,
	input wire logic                                               psel,
	input wire logic                                               penable,
	input wire logic                                               pwrite,
	input wire logic [11:0]                                        paddr,
	input wire logic                                               pready,
	input wire logic [31:0]                                        prdata,
	input wire logic                                               pslverr,
	input wire logic [BerFlags-1:0][switch_flags_pkg::COUNT_W-1:0] berReceiverErrorCount,
	input wire logic                                               outputCapacityError,
	input wire logic                                               inputCapacityError,
	input wire logic [BerFlags-1:0]                                berStreamErrorFlag,
	input wire switch_flags_pkg::stream_cfg_t [Streams-1:0]        inStreamCfg,
	input wire switch_flags_pkg::stream_cfg_t [Streams-1:0]        outStreamCfg
);
	localparam int Cap = switch_flags_pkg::CAPACITY_CHANNELS;
	logic [15:0]          inSum;
	logic [15:0]          outSum;
	logic [BerFlags-1:0]  nzNow;

	// Totals are two bits wider than the design's so that 32 fast streams cannot wrap here.
	always_comb begin
		inSum = 16'h0000;
		outSum = 16'h0000;
		for (int i = 0; i < Streams; i++) begin
			if (inStreamCfg[i].enable) inSum += 16'h0020 << inStreamCfg[i].rate;
			if (outStreamCfg[i].enable) outSum += 16'h0020 << outStreamCfg[i].rate;
		end
		for (int n = 0; n < BerFlags; n++) nzNow[n] = |berReceiverErrorCount[n];
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence readAcc;
		psel && penable && pready && !pwrite;
	endsequence
	sequence bothFit;
		(inSum <= Cap && outSum <= Cap) [*2];
	endsequence

	chk_ber_track: assert property (!$past(rst) |-> berStreamErrorFlag == $past(nzNow))
		else $error("Error flag does not follow its count.");
	chk_ber_reset: assert property ($past(rst) |-> berStreamErrorFlag == '0)
		else $error("Error flags not clear after reset.");
	chk_out_cap: assert property (!$past(rst) |->
		outputCapacityError == ($past(outSum) > Cap))
		else $error("Output capacity flag wrong.");
	chk_in_cap: assert property (!$past(rst) |-> inputCapacityError == ($past(inSum) > Cap))
		else $error("Input capacity flag wrong.");
	chk_self_clear: assert property (bothFit |-> !inputCapacityError && !outputCapacityError)
		else $error("Capacity flag stuck after fix.");
	chk_ro_refuse: assert property (psel && penable && pready && pwrite &&
		(paddr[11:2] == switch_flags_pkg::IDX_CAP_FLAGS ||
		paddr[11:2] == switch_flags_pkg::IDX_BER_FLAGS) |-> pslverr)
		else $error("Write to read-only flags accepted.");
	chk_cap_read: assert property (readAcc ##0 paddr[11:2] == switch_flags_pkg::IDX_CAP_FLAGS
		|-> prdata == {30'h0, $past(outputCapacityError), $past(inputCapacityError)})
		else $error("Capacity word read wrong.");
	chk_ber_read: assert property (readAcc ##0 paddr[11:2] == switch_flags_pkg::IDX_BER_FLAGS
		|-> prdata == 32'($past(berStreamErrorFlag)))
		else $error("Error flag word read wrong.");
endmodule

bind switch_capacity_and_ber_flags switch_flags_props #(.Streams(Streams), .BerFlags(BerFlags))
	props_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
	.berReceiverErrorCount, .outputCapacityError, .inputCapacityError, .berStreamErrorFlag,
	.inStreamCfg, .outStreamCfg);

// *** dv/switch_capacity_and_ber_flags_tb.sv ***
// Purpose: Self-checking bench for the capacity and bit-error flag register bank.
// Assumes: APB master drives right after rising edges; the transfer task waits out any wait states.
// Notes:   Capacity cases sit in a table; reset, refusals and interrupts follow by hand.
`timescale 1ns/10ps
module switch_capacity_and_ber_flags_tb;
	logic                                 ref_clk, rst, psel, penable, pwrite;
	logic                                 pready, pslverr, irq, err, output_capacity_error, input_capacity_error;
	logic [11:0]                          paddr;
	logic [31:0]                          pwdata, prdata, rd;
	logic [15:0][15:0]                    cnt;
	logic [15:0]                          berFlag, fpOff;
	switch_flags_pkg::stream_cfg_t [31:0] inCfg, outCfg;
	int                                   fail_count, n_checks, cyc;
	// One row: streams and rate per side, then the expected {out, in} flags.
	typedef struct {int nIn; int rIn; int nOut; int rOut; logic [1:0] exp;} row_t;
	row_t rows [7] = '{'{16, 3, 0, 0, 2'h0}, '{17, 3, 0, 0, 2'h1}, '{0, 0, 17, 3, 2'h2},
		'{32, 2, 32, 3, 2'h2}, '{32, 0, 32, 1, 2'h0}, '{17, 3, 17, 3, 2'h3}, '{16, 3, 16, 3, 2'h0}};

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

	switch_capacity_and_ber_flags uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .berReceiverErrorCount(cnt),
		.outputCapacityError(output_capacity_error), .inputCapacityError(input_capacity_error), .berStreamErrorFlag(berFlag),
		.framePulseOffset(fpOff), .inStreamCfg(inCfg), .outStreamCfg(outCfg), .irq);

	// Free-running clock.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic test_done;
		if (fail_count == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// One APB transfer; it waits for pready as long as it takes, and only the
	// bench's cycle ceiling ends a wait that never sees it.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	// Hang guard well above the roughly 1600 cycles the sequence needs.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			test_done();
		end
	end

	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata, cnt} = {1'b1, 47'h0, 256'h0};
		{fail_count, n_checks, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (rows[k]) begin
			for (int i = 0; i < 32; i++) begin
				apb(1'b1, 12'h100 + 12'(4 * i), {29'h0, i < rows[k].nIn, 2'(rows[k].rIn)});
				apb(1'b1, 12'h180 + 12'(4 * i), {29'h0, i < rows[k].nOut, 2'(rows[k].rOut)});
			end
			repeat (2) @(posedge ref_clk);
			apb(1'b0, 12'h040, 32'h0);
			`CHK(rd, {30'h0, rows[k].exp})
			`CHK({output_capacity_error, input_capacity_error}, rows[k].exp)
		end
		// Writes to the flag words are refused and change nothing; an unmapped read and a read of the clear word are refused too.
		apb(1'b1, 12'h040, 32'h3);
		`CHK({err, rd}, {1'b1, 32'h0})
		apb(1'b0, 12'h040, 32'h0);
		`CHK(rd, 32'h0)
		apb(1'b1, 12'h044, 32'hffff);
		`CHK(err, 1'b1)
		apb(1'b0, 12'hffc, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b0, 12'h084, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		// The frame pulse offset keeps only its defined low bits.
		apb(1'b1, 12'h03c, 32'hffff);
		`CHK(err, 1'b0)
		apb(1'b0, 12'h03c, 32'h0);
		`CHK(rd, {16'h0, switch_flags_pkg::FP_OFFSET_MASK})
		`CHK(fpOff, switch_flags_pkg::FP_OFFSET_MASK)
		// Walk one nonzero count across the sixteen receivers, 0x0001 on even ones and 0x8000 on odd ones.
		for (int n = 0; n < 16; n++) begin
			cnt <= 256'(n[0] ? 16'h8000 : 16'h0001) << (16 * n);
			repeat (3) @(posedge ref_clk);
			`CHK(berFlag, 16'h1 << n)
			apb(1'b0, 12'h044, 32'h0);
			`CHK(rd, 32'h1 << n)
		end
		// Interrupt: raise on receiver 0, mask it, then clear the sticky bit.
		cnt <= 256'h0;
		apb(1'b1, 12'h084, 32'h3ffff);
		apb(1'b1, 12'h088, 32'h4);
		cnt <= 256'h1;
		repeat (4) @(posedge ref_clk);
		`CHK(irq, 1'b1)
		apb(1'b1, 12'h088, 32'h0);
		apb(1'b0, 12'h080, 32'h0);
		`CHK({irq, rd}, {1'b0, 32'h4})
		apb(1'b1, 12'h084, 32'h4);
		apb(1'b0, 12'h080, 32'h0);
		`CHK(rd, 32'h0)
		// Overflow the input side, then reset in mid-run.
		for (int i = 0; i < 17; i++) apb(1'b1, 12'h100 + 12'(4 * i), 32'h7);
		repeat (2) @(posedge ref_clk);
		`CHK(input_capacity_error, 1'b1)
		`CHK({inCfg[16], outCfg[15], outCfg[16]}, 9'h1fb)
		apb(1'b0, 12'h140, 32'h0);
		`CHK(rd, 32'h7)
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		`CHK({input_capacity_error, berFlag}, 17'h0)
		`CHK({irq, inCfg[16], outCfg[15]}, 7'h00)
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK({input_capacity_error, berFlag}, 17'h1)
		test_done();
	end
endmodule
